// >>> logic/dsic_top.sv
// sample input controller of a baseband demodulator with its pin-level
// controls: loop freezes, lock interrupt, threshold, slow and symbol clocks,
// three-state output enables.
// assumes parallel samples timed to ref_clk_in, serial samples timed to
// serial_in_clock, and only the loop freeze and output enable pins asynchronous.

module dsic_top
   import dsic_pkg::*;
#(
   parameter int PIPE_STAGES = 2
) (
   input  wire logic                     ref_clk_in,
   input  wire logic                     rst_in,
   input  wire logic [dsic_pkg::CFG_W-1:0] datapath_cfg_in,
   input  wire logic [dsic_pkg::SAMPLE_W-1:0] inphase_parallel_in,
   input  wire logic [dsic_pkg::SAMPLE_W-1:0] quad_parallel_in,
   input  wire logic                     input_sync_n_in,
   input  wire logic                     serial_in_clock,
   input  wire logic                     inphase_serial_in,
   input  wire logic                     quad_serial_in,
   input  wire logic                     serial_word_sync_in,
   output      dsic_pkg::dsic_tagged_t   pipe_sample_out,
   input  wire logic                     symbol_loop_freeze_in,
   input  wire logic                     carrier_loop_freeze_in,
   input  wire logic [dsic_pkg::ERR_W-1:0] symbol_timing_err_in,
   input  wire logic [dsic_pkg::ERR_W-1:0] carrier_phase_err_in,
   output      logic [dsic_pkg::ERR_W-1:0] symbol_filter_err_out,
   output      logic [dsic_pkg::ERR_W-1:0] carrier_filter_err_out,
   input  wire logic                     lock_cycle_done_in,
   input  wire logic                     lock_irq_extend_in,
   output      logic                     lock_done_irq_out,
   input  wire logic [dsic_pkg::MAG_W-1:0] polar_magnitude_in,
   input  wire logic [dsic_pkg::MAG_W-1:0] power_threshold_in,
   output      logic                     power_over_threshold_n_out,
   input  wire logic [dsic_pkg::DIV_W-1:0] slow_clock_half_in,
   output      logic                     slow_serial_clock_out,
   input  wire logic                     soft_decision_strobe_in,
   output      logic                     recovered_symbol_clock_out,
   input  wire logic [dsic_pkg::SAMPLE_W-1:0] port_a_data_in,
   input  wire logic [dsic_pkg::SAMPLE_W-1:0] port_b_data_in,
   input  wire logic                     port_a_out_enable_n_in,
   input  wire logic                     port_b_out_enable_n_in,
   output      logic [dsic_pkg::SAMPLE_W-1:0] port_a_output_out,
   output      logic                     port_a_output_oe_out,
   output      logic [dsic_pkg::SAMPLE_W-1:0] port_b_output_out,
   output      logic                     port_b_output_oe_out
);
   import dsic_pkg::*;

   // offset binary to two's complement: flip the sign bit
   function automatic logic [SAMPLE_W-1:0] to_twos(input logic [SAMPLE_W-1:0] v,
                                                    input logic offbin);
      to_twos = offbin ? (v ^ SAMPLE_MSB_MASK) : v;
   endfunction

   // ---------------- serial link domain ----------------
   logic [SAMPLE_W-1:0]  ser_i_shift_reg;
   logic [SAMPLE_W-1:0]  ser_q_shift_reg;
   logic [BIT_CNT_W-1:0] ser_cnt_reg;
   logic                 ser_full_reg;
   dsic_sample_t         ser_hold_reg;
   logic                 ser_toggle_reg;
   wire                  ser_shifting  = (ser_cnt_reg != SER_WORD_BITS);
   wire                  ser_word_done = (ser_cnt_reg == SER_WORD_BITS - 4'h0001);
   wire                  ser_shift_en  = !serial_word_sync_in && ser_shifting;
   wire                  ser_xfer      = serial_word_sync_in && ser_full_reg;
   logic [BIT_CNT_W-1:0] ser_cnt_next;
   logic                 ser_full_next;

   // bit counter: sync rearms, ten shifts, then parked
   assign ser_cnt_next  = serial_word_sync_in ? SER_CNT_ZERO
                        : ser_shift_en ? ser_cnt_reg + 4'h0001 : ser_cnt_reg;
   assign ser_full_next = serial_word_sync_in ? 1'b0
                        : ser_shift_en ? ser_word_done : ser_full_reg;

   always_ff @(posedge serial_in_clock or posedge rst_in) begin
      if (rst_in) begin
         ser_cnt_reg  <= SER_WORD_BITS;
         ser_full_reg <= 1'b0;
      end else begin
         ser_cnt_reg  <= ser_cnt_next;
         ser_full_reg <= ser_full_next;
      end
   end

   // shift registers, msb arrives first
   always_ff @(posedge serial_in_clock or posedge rst_in) begin
      if (rst_in) begin
         ser_i_shift_reg <= SAMPLE_ZERO;
         ser_q_shift_reg <= SAMPLE_ZERO;
      end else if (ser_shift_en) begin
         ser_i_shift_reg <= {ser_i_shift_reg[SAMPLE_W-2:0], inphase_serial_in};
         ser_q_shift_reg <= {ser_q_shift_reg[SAMPLE_W-2:0], quad_serial_in};
      end
   end

   // held word moves out on sync
   always_ff @(posedge serial_in_clock or posedge rst_in) begin
      if (rst_in) begin
         ser_hold_reg <= '0;
      end else if (ser_xfer) begin
         ser_hold_reg <= '{inphase: ser_i_shift_reg, quad: ser_q_shift_reg};
      end
   end

   // toggle marks each transfer for the system domain
   always_ff @(posedge serial_in_clock or posedge rst_in) begin
      if (rst_in) begin
         ser_toggle_reg <= 1'b0;
      end else if (ser_xfer) begin
         ser_toggle_reg <= ~ser_toggle_reg;
      end
   end

   // ---------------- system clock domain ----------------
   logic [2:0]   tog_sync_reg;
   logic [1:0]   sym_frz_sync_reg;
   logic [1:0]   car_frz_sync_reg;
   logic [1:0]   oea_sync_reg;
   logic [1:0]   oeb_sync_reg;

   // event crossing: two flops, third flop for the edge
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tog_sync_reg <= 3'h0;
      end else begin
         tog_sync_reg <= {tog_sync_reg[1:0], ser_toggle_reg};
      end
   end

   // symbol freeze pin, two flops
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sym_frz_sync_reg <= 2'h0;
      end else begin
         sym_frz_sync_reg <= {sym_frz_sync_reg[0], symbol_loop_freeze_in};
      end
   end

   // carrier freeze pin, two flops
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         car_frz_sync_reg <= 2'h0;
      end else begin
         car_frz_sync_reg <= {car_frz_sync_reg[0], carrier_loop_freeze_in};
      end
   end

   // port a enable pin, two flops, resets to float
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         oea_sync_reg <= 2'h3;
      end else begin
         oea_sync_reg <= {oea_sync_reg[0], port_a_out_enable_n_in};
      end
   end

   // port b enable pin, two flops, resets to float
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         oeb_sync_reg <= 2'h3;
      end else begin
         oeb_sync_reg <= {oeb_sync_reg[0], port_b_out_enable_n_in};
      end
   end

   wire ser_event = tog_sync_reg[2] ^ tog_sync_reg[1];

   // source selection from configuration
   wire       cfg_serial = datapath_cfg_in[CFG_SERIAL_BIT];
   wire       cfg_offbin = datapath_cfg_in[CFG_OFFBIN_BIT];
   dsic_src_t src_sel;
   assign src_sel = cfg_serial ? DSIC_SRC_SERIAL : DSIC_SRC_PARALLEL;

   wire par_take = ~input_sync_n_in;

   dsic_tagged_t stage_next;
   always_comb begin
      stage_next = '0;
      unique case (src_sel)
         DSIC_SRC_PARALLEL: begin
            stage_next.enable         = par_take;
            stage_next.sample.inphase = to_twos(inphase_parallel_in, cfg_offbin);
            stage_next.sample.quad    = to_twos(quad_parallel_in, cfg_offbin);
         end
         DSIC_SRC_SERIAL: begin
            stage_next.enable         = ser_event;
            stage_next.sample.inphase = to_twos(ser_hold_reg.inphase, cfg_offbin);
            stage_next.sample.quad    = to_twos(ser_hold_reg.quad, cfg_offbin);
         end
      endcase
   end

   // pipeline with the enable carried beside each sample
   dsic_tagged_t pipe_reg [PIPE_STAGES];

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pipe_reg[0] <= '0;
      end else if (stage_next.enable) begin
         pipe_reg[0] <= stage_next;
      end else begin
         pipe_reg[0].enable <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 1; g < PIPE_STAGES; g++) begin : g_pipe
         always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
               pipe_reg[g] <= '0;
            end else begin
               pipe_reg[g] <= pipe_reg[g-1];
            end
         end
      end
   endgenerate

   assign pipe_sample_out = pipe_reg[PIPE_STAGES-1];

   // loop freezes
   wire [ERR_W-1:0] sym_err_next = sym_frz_sync_reg[1] ? ERR_ZERO
                                                       : symbol_timing_err_in;
   wire [ERR_W-1:0] car_err_next = car_frz_sync_reg[1] ? ERR_ZERO
                                                       : carrier_phase_err_in;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         symbol_filter_err_out <= ERR_ZERO;
      end else begin
         symbol_filter_err_out <= sym_err_next;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         carrier_filter_err_out <= ERR_ZERO;
      end else begin
         carrier_filter_err_out <= car_err_next;
      end
   end

   // lock interrupt stretch
   logic [2:0] lock_cnt_reg;
   logic [2:0] lock_cnt_next;
   wire        lock_active = (lock_cnt_reg != LOCK_CNT_ZERO);

   assign lock_cnt_next = lock_cycle_done_in ? LOCK_IRQ_LOAD
                        : lock_active ? lock_cnt_reg - 3'h1 : LOCK_CNT_ZERO;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         lock_cnt_reg      <= LOCK_CNT_ZERO;
         lock_done_irq_out <= 1'b0;
      end else begin
         lock_cnt_reg      <= lock_cnt_next;
         lock_done_irq_out <= (lock_cnt_next != LOCK_CNT_ZERO)
                              || (lock_done_irq_out && lock_irq_extend_in);
      end
   end

   // threshold compare, active low
   wire power_over = (polar_magnitude_in > power_threshold_in);

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         power_over_threshold_n_out <= 1'b1;
      end else begin
         power_over_threshold_n_out <= ~power_over;
      end
   end

   // slow clock divider, equal high and low halves
   logic [DIV_W-1:0] slow_cnt_reg;
   wire              slow_wrap = (slow_cnt_reg >= slow_clock_half_in);
   wire  [DIV_W-1:0] slow_cnt_inc = slow_cnt_reg + 8'h01;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         slow_cnt_reg          <= DIV_ZERO;
         slow_serial_clock_out <= 1'b0;
      end else if (slow_wrap) begin
         slow_cnt_reg          <= DIV_ZERO;
         slow_serial_clock_out <= ~slow_serial_clock_out;
      end else begin
         slow_cnt_reg <= slow_cnt_inc;
      end
   end

   // symbol clock: high at each decision, low after half the measured period
   logic [SYM_CNT_W-1:0] sym_period_cnt_reg;
   logic [SYM_CNT_W-1:0] sym_half_reg;
   logic [SYM_CNT_W-1:0] sym_hi_cnt_reg;
   wire                  sym_hi_done = (sym_hi_cnt_reg >= sym_half_reg);
   wire                  sym_clk_next = soft_decision_strobe_in ? 1'b1
                                      : sym_hi_done ? 1'b0 : recovered_symbol_clock_out;

   // period measure and high-time count
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sym_period_cnt_reg <= SYM_ONE;
         sym_half_reg       <= SYM_ONE;
         sym_hi_cnt_reg     <= SYM_ZERO;
      end else if (soft_decision_strobe_in) begin
         sym_period_cnt_reg <= SYM_ONE;
         sym_half_reg       <= sym_period_cnt_reg >> 1;
         sym_hi_cnt_reg     <= SYM_ONE;
      end else begin
         sym_period_cnt_reg <= sym_period_cnt_reg + SYM_ONE;
         sym_hi_cnt_reg     <= sym_hi_cnt_reg + SYM_ONE;
      end
   end

   // symbol clock output
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         recovered_symbol_clock_out <= 1'b0;
      end else begin
         recovered_symbol_clock_out <= sym_clk_next;
      end
   end

   // port a data and its three-state enable
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         port_a_output_out    <= SAMPLE_ZERO;
         port_a_output_oe_out <= 1'b0;
      end else begin
         port_a_output_out    <= port_a_data_in;
         port_a_output_oe_out <= ~oea_sync_reg[1];
      end
   end

   // port b data and its three-state enable
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         port_b_output_out    <= SAMPLE_ZERO;
         port_b_output_oe_out <= 1'b0;
      end else begin
         port_b_output_out    <= port_b_data_in;
         port_b_output_oe_out <= ~oeb_sync_reg[1];
      end
   end

endmodule

// >>> logic/dsic_pkg.sv
// package for the demodulator sample input controller: widths, config
// bit positions, timing counts and the sample carrier types.
// assumes a single system clock at 100 MHz and one serial link clock.
package dsic_pkg;

   localparam int SAMPLE_W       = 10;
   localparam int CFG_W          = 24;
   localparam int ERR_W          = 16;
   localparam int MAG_W          = 16;
   localparam int DIV_W          = 8;
   localparam int SYM_CNT_W      = 16;
   localparam int BIT_CNT_W      = 4;

   // data path configuration word fields
   localparam int CFG_SERIAL_BIT = 14;
   localparam int CFG_OFFBIN_BIT = 15;

   // serial word length in bits
   localparam logic [BIT_CNT_W-1:0] SER_WORD_BITS = 4'h000a;
   localparam logic [BIT_CNT_W-1:0] SER_CNT_ZERO  = 4'h0000;

   // lock interrupt least high time, in system clocks
   localparam int SYS_CLK_PERIOD_NS  = 10;
   localparam int LOCK_IRQ_MIN_NS    = 40;
   localparam int LOCK_IRQ_MIN_CYC   =
      (LOCK_IRQ_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam logic [2:0] LOCK_IRQ_LOAD = 3'(LOCK_IRQ_MIN_CYC);
   localparam logic [2:0] LOCK_CNT_ZERO = 3'h0;

   localparam logic [SAMPLE_W-1:0] SAMPLE_MSB_MASK = 10'h0200;
   localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO     = 10'h0000;
   localparam logic [ERR_W-1:0]    ERR_ZERO        = 16'h0000;
   localparam logic [DIV_W-1:0]    DIV_ZERO        = 8'h00;
   localparam logic [SYM_CNT_W-1:0] SYM_ZERO       = 16'h0000;
   localparam logic [SYM_CNT_W-1:0] SYM_ONE        = 16'h0001;

   typedef struct packed {
      logic [SAMPLE_W-1:0] inphase;
      logic [SAMPLE_W-1:0] quad;
   } dsic_sample_t;

   typedef struct packed {
      logic         enable;
      dsic_sample_t sample;
   } dsic_tagged_t;

   typedef enum logic [1:0] {
      DSIC_SRC_PARALLEL = 2'b01,
      DSIC_SRC_SERIAL   = 2'b10
   } dsic_src_t;

endpackage

// >>> verif/dsic_chk.sv
// checker bound to the sample input controller top level.
// assumes one system clock domain and the default pipe depth.
module dsic_chk
   import dsic_pkg::*;
#(parameter int PIPE_STAGES = 2) (
   input wire logic                ref_clk_in,
   input wire logic                rst_in,
   input wire logic [CFG_W-1:0]    datapath_cfg_in,
   input wire logic [SAMPLE_W-1:0] inphase_parallel_in,
   input wire logic                input_sync_n_in,
   input wire dsic_tagged_t        pipe_sample_out,
   input wire logic                symbol_loop_freeze_in,
   input wire logic                carrier_loop_freeze_in,
   input wire logic [ERR_W-1:0]    symbol_filter_err_out,
   input wire logic [ERR_W-1:0]    carrier_filter_err_out,
   input wire logic                lock_cycle_done_in,
   input wire logic                lock_done_irq_out,
   input wire logic [MAG_W-1:0]    polar_magnitude_in,
   input wire logic [MAG_W-1:0]    power_threshold_in,
   input wire logic                power_over_threshold_n_out,
   input wire logic [DIV_W-1:0]    slow_clock_half_in,
   input wire logic                slow_serial_clock_out,
   input wire logic                port_a_out_enable_n_in,
   input wire logic                port_b_out_enable_n_in,
   input wire logic                port_a_output_oe_out,
   input wire logic                port_b_output_oe_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_par_take;
      !datapath_cfg_in[CFG_SERIAL_BIT] && !input_sync_n_in;
   endsequence
   sequence s_slow_high;
      slow_serial_clock_out [*4] ##1 !slow_serial_clock_out;
   endsequence
   a_par_admit: assert property (s_par_take |-> ##2 (pipe_sample_out.enable &&
      pipe_sample_out.sample.inphase == ($past(inphase_parallel_in, 2) ^
      ($past(datapath_cfg_in[CFG_OFFBIN_BIT], 2) ? SAMPLE_MSB_MASK : SAMPLE_ZERO))))
      else $error("parallel sample not admitted");
   a_sym_freeze: assert property (symbol_loop_freeze_in [*4] |->
      symbol_filter_err_out == ERR_ZERO) else $error("symbol error passed while frozen");
   a_car_freeze: assert property (carrier_loop_freeze_in [*4] |->
      carrier_filter_err_out == ERR_ZERO) else $error("carrier error passed while frozen");
   a_lock_irq_hold: assert property (lock_cycle_done_in |=> lock_done_irq_out [*4])
      else $error("lock interrupt shorter than four clocks");
   a_power_over_threshold_n_sense: assert property (1'b1 |=> power_over_threshold_n_out ==
      !($past(polar_magnitude_in) > $past(power_threshold_in))) else $error("bad threshold flag");
   a_slow_half: assert property ($rose(slow_serial_clock_out) &&
      slow_clock_half_in == 8'h03 |-> s_slow_high) else $error("slow clock half period wrong");
   a_port_a_float: assert property (
      port_a_out_enable_n_in [*4] |-> !port_a_output_oe_out) else $error("port a driven");
   a_port_b_float: assert property (
      port_b_out_enable_n_in [*4] |-> !port_b_output_oe_out) else $error("port b driven");
endmodule

bind dsic_top dsic_chk #(.PIPE_STAGES(PIPE_STAGES)) chk (.*);

// >>> verif/dsic_ser_src.sv
// serial sample source at the far side of the link.
// assumes its clock stands low between words and no pull on the lines.
module dsic_ser_src (
   output logic serial_in_clock,
   output logic inphase_serial_in,
   output logic quad_serial_in,
   output logic serial_word_sync_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {serial_in_clock, inphase_serial_in, quad_serial_in, serial_word_sync_in} = 4'h0;
   // one link clock, lines set while the clock is low
   task automatic tick(input logic s, input logic i, input logic q);
      {serial_word_sync_in, inphase_serial_in, quad_serial_in} = {s, i, q};
      #83 serial_in_clock = 1'b1;
      #77 serial_in_clock = 1'b0;
   endtask
   // optional sync, then n bits msb first; extra bits are junk
   task automatic send(input logic [9:0] i, input logic [9:0] q, input int n, input logic s);
      if (s) tick(1'b1, ~i[9], ~q[9]);
      for (int k = 0; k < n; k++)
         tick(1'b0, k < 10 ? i[9-k] : ~i[0], k < 10 ? q[9-k] : ~q[0]);
      #1 serial_word_sync_in = 1'b0;
      {inphase_serial_in, quad_serial_in} = ~{inphase_serial_in, quad_serial_in};
   endtask
endmodule

// >>> verif/dsic_top_tb.sv
// self-checking bench for the sample input controller top level.
// assumes the serial source model and the bound checker.
module dsic_top_tb
   import dsic_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_in, rst_in, input_sync_n_in, lock_cycle_done_in, lock_irq_extend_in;
   logic symbol_loop_freeze_in, carrier_loop_freeze_in, soft_decision_strobe_in;
   logic port_a_out_enable_n_in, port_b_out_enable_n_in, lock_done_irq_out;
   logic power_over_threshold_n_out, slow_serial_clock_out, recovered_symbol_clock_out;
   logic port_a_output_oe_out, port_b_output_oe_out;
   logic [CFG_W-1:0] datapath_cfg_in;
   logic [SAMPLE_W-1:0] inphase_parallel_in, quad_parallel_in, port_a_data_in, port_b_data_in;
   logic [SAMPLE_W-1:0] port_a_output_out, port_b_output_out;
   logic [ERR_W-1:0] symbol_timing_err_in, carrier_phase_err_in;
   logic [ERR_W-1:0] symbol_filter_err_out, carrier_filter_err_out;
   logic [MAG_W-1:0] polar_magnitude_in, power_threshold_in;
   logic [DIV_W-1:0] slow_clock_half_in;
   dsic_tagged_t pipe_sample_out;
   wire serial_in_clock, inphase_serial_in, quad_serial_in, serial_word_sync_in;
   int num_errors, n_compared, cyc;
   dsic_top #(.PIPE_STAGES(2)) dut (.*);
   dsic_ser_src src (.*);
   initial ref_clk_in = 1'b0;
   always #5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) if (++cyc == 6000) begin
      num_errors++;
      tally_and_finish();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d of %0d compares", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // back-to-back parallel samples, one refused, both formats
   task automatic t_par;
      logic [9:0] v [4] = '{10'h200, 10'h1ff, 10'h155, 10'h3ff};
      for (int f = 0; f < 2; f++) begin
         datapath_cfg_in = f ? 24'h00_8000 : 24'h00_0000;
         for (int i = 0; i < 7; i++) begin
            @(negedge ref_clk_in);
            if (i >= 2) chk(pipe_sample_out.enable, i != 4 && i < 6);
            if (i >= 2 && i != 4 && i < 6)
               chk(pipe_sample_out.sample, {v[i-2], ~v[i-2]} ^ (f ? 20'h8_0200 : 20'h0));
            input_sync_n_in = (i == 2) || (i > 3);
            {inphase_parallel_in, quad_parallel_in} = {v[i%4], ~v[i%4]};
         end
      end
   endtask
   // short word, long word, full word, closing sync
   task automatic t_ser;
      dsic_sample_t got [$];
      logic [19:0] m;
      for (int f = 0; f < 2; f++) begin
         datapath_cfg_in = f ? 24'h00_c000 : 24'h00_4000;
         m = f ? 20'h8_0200 : 20'h0_0000;
         got.delete();
         fork
            begin
               src.send(10'h2a5, 10'h15a, 5, 1'b1);
               src.send(10'h3c1, 10'h03e, 12, 1'b1);
               src.send(10'h200, 10'h1ff, 10, 1'b1);
               src.send(10'h000, 10'h000, 0, 1'b1);
            end
            repeat (800) begin
               @(negedge ref_clk_in);
               if (pipe_sample_out.enable === 1'b1) got.push_back(pipe_sample_out.sample);
            end
         join
         chk(got.size(), 2);
         chk(got[0], {10'h3c1, 10'h03e} ^ m);
         chk(got[1], {10'h200, 10'h1ff} ^ m);
      end
   endtask
   // freezes, threshold, output enables, lock interrupt
   task automatic t_pins;
      {symbol_timing_err_in, carrier_phase_err_in} = 32'h1234_5678;
      for (int k = 0; k < 3; k++) begin
         symbol_loop_freeze_in = k == 1;
         carrier_loop_freeze_in = k == 2;
         {port_a_out_enable_n_in, port_b_out_enable_n_in} = {k != 1, k == 1};
         {port_a_data_in, port_b_data_in} = {10'h155 ^ 10'(k), 10'h2aa ^ 10'(k)};
         polar_magnitude_in = 16'h07ff + 16'(k);
         repeat (4) @(negedge ref_clk_in);
         chk(symbol_filter_err_out, k == 1 ? 16'h0000 : 16'h1234);
         chk(carrier_filter_err_out, k == 2 ? 16'h0000 : 16'h5678);
         chk(power_over_threshold_n_out, k != 2);
         chk({port_a_output_oe_out, port_b_output_oe_out}, {k == 1, k != 1});
         if (k == 1) chk(port_a_output_out, port_a_data_in);
         else chk(port_b_output_out, port_b_data_in);
      end
      for (int p = 0; p < 3; p++)
         for (int c = 0; c < 8; c++) begin
            soft_decision_strobe_in = c == 0;
            @(negedge ref_clk_in);
            if (p == 2) chk(recovered_symbol_clock_out, c < 4);
         end
      lock_cycle_done_in = 1'b1;
      for (int i = 0; i < 6; i++) begin
         @(negedge ref_clk_in);
         lock_cycle_done_in = 1'b0;
         chk(lock_done_irq_out, i < 4);
      end
      lock_irq_extend_in = 1'b1;
      lock_cycle_done_in = 1'b1;
      @(negedge ref_clk_in);
      lock_cycle_done_in = 1'b0;
      repeat (6) @(negedge ref_clk_in);
      chk(lock_done_irq_out, 1'b1);
      lock_irq_extend_in = 1'b0;
      @(negedge ref_clk_in);
      chk(lock_done_irq_out, 1'b0);
   endtask
   initial begin
      {rst_in, input_sync_n_in, port_a_out_enable_n_in, port_b_out_enable_n_in} = 4'hf;
      {lock_cycle_done_in, lock_irq_extend_in, soft_decision_strobe_in} = 3'h0;
      {symbol_loop_freeze_in, carrier_loop_freeze_in, datapath_cfg_in} = 26'h000_0000;
      {inphase_parallel_in, quad_parallel_in, port_a_data_in, port_b_data_in} = 40'h0;
      {symbol_timing_err_in, carrier_phase_err_in} = 32'h0000_0000;
      {polar_magnitude_in, power_threshold_in} = 32'h0000_0800;
      slow_clock_half_in = 8'h03;
      fork
         repeat (5) @(negedge ref_clk_in);
         src.send(10'h000, 10'h000, 2, 1'b0);
      join
      chk(power_over_threshold_n_out, 1'b1);
      chk(port_a_output_oe_out, 1'b0);
      @(negedge ref_clk_in);
      rst_in = 1'b0;
      t_par();
      t_ser();
      t_pins();
      tally_and_finish();
   end
endmodule
